// ==== hdl/esw_walker.sv ====
// Walker that runs the transfer list to save or load register bytes.
// Assumes a register bank answering reads one cycle later, and a
// nonvolatile store that completes each request on nv_ready_in.
//
// Operation
// - MSB clear command means data move
// - Low seven bits are byte count minus one
// - Address follows command, high byte first
// - MSB set command means operational code
// - Commit copies buffered registers to active
// - End code stops walk and transfer
// - Move named bytes to store or back
// - Reset loads default save-all-and-commit list
// - Commit takes effect on next edge
// - Pending flag high while transfer runs
// - Save trigger starts save, self-clears after
`default_nettype none
`timescale 1ns/1ps

module esw_walker
	import esw_pkg::*;
#(
	parameter int NV_AW = 9                    // Store address width
) (
	input  wire logic             clock_in,        // System clock
	input  wire logic             sys_rst_in,      // Synchronous reset
	// Serial control port view of the list area
	input  wire logic [11:0]      scp_addr_in,     // Register address
	input  wire logic [7:0]       scp_wdata_in,    // Write data
	input  wire logic             scp_wr_in,       // Write strobe
	input  wire logic             scp_rd_in,       // Read strobe
	output logic [7:0]            scp_rdata_out,   // Read data
	output logic                  scp_rvalid_out,  // Read data valid pulse
	// Triggers and status
	input  wire logic             save_trigger_in, // Start save pulse
	input  wire logic             load_trigger_in, // Start load pulse
	output logic                  save_trigger_out,// Save bit readback
	output logic                  pending_out,     // Transfer in progress
	output logic                  commit_out,      // Buffered to active pulse
	// Register bank
	output logic [15:0]           bank_addr_out,   // Register address
	output logic                  bank_rd_out,     // Read strobe
	output logic                  bank_wr_out,     // Write strobe
	output logic [7:0]            bank_wdata_out,  // Write data
	input  wire logic [7:0]       bank_rdata_in,   // Read data, next cycle
	// Nonvolatile store
	output logic [NV_AW-1:0]      nv_addr_out,     // Store address
	output logic                  nv_rd_out,       // Read request
	output logic                  nv_wr_out,       // Write request
	output logic [7:0]            nv_wdata_out,    // Write data
	input  wire logic [7:0]       nv_rdata_in,     // Read data
	input  wire logic             nv_ready_in      // Request done
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	esw_state_t      state;                    // Walker state
	logic            save_mode;                // High: save, low: load
	logic [LIST_AW:0] ptr;                     // List index, top bit is overrun
	logic [6:0]      remain;                   // Bytes left minus one
	logic [15:0]     reg_addr;                 // Current register address
	logic [7:0]      data;                     // Byte in flight
	logic [NV_AW-1:0] nv_addr;                 // Current store address
	logic [7:0]      list_rdata;               // List memory read data
	esw_list_req_t   list_req;                 // List memory request
	logic            scp_hit;                  // Port address in list area
	logic            busy;                     // Walk in progress
	logic            list_rd;                  // Walker reads list this cycle
	logic            last_byte;                // Final byte of a move
	logic            byte_done;                // A byte finished this cycle

	assign busy      = (state != ST_IDLE);
	assign scp_hit   = (scp_addr_in[11:8] == LIST_PAGE);
	assign list_rd   = (state == ST_CMD_RD) || (state == ST_AHI_RD) ||
	                   (state == ST_ALO_RD);
	assign last_byte = (remain == 7'h00);
	assign byte_done = ((state == ST_NV_WR) && nv_ready_in) || (state == ST_BANK_WR);

	// ----------------------------------------------------------------
	// List memory and port arbitration
	// ----------------------------------------------------------------
	// Walker owns the memory while busy; port writes then are dropped
	// so the list cannot change under a running walk.
	always_comb begin
		list_req = '0;
		if (busy) begin
			list_req.addr = ptr[LIST_AW-1:0];
			list_req.rd   = list_rd;
		end else begin
			list_req.addr  = scp_addr_in[LIST_AW-1:0];
			list_req.wdata = scp_wdata_in;
			list_req.wr    = scp_hit && scp_wr_in;
			list_req.rd    = scp_hit && scp_rd_in;
		end
	end

	esw_list_mem #(
		.DEPTH     (LIST_DEPTH)
	) u_list_mem (
		.clock_in  (clock_in),
		.sys_rst_in(sys_rst_in),
		.req_in    (list_req),
		.rdata_out (list_rdata)
	);

	// Port read answer one cycle after the strobe
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			scp_rvalid_out <= 1'b0;
		end else begin
			scp_rvalid_out <= !busy && scp_hit && scp_rd_in;
		end
	end

	assign scp_rdata_out = list_rdata;

	// ----------------------------------------------------------------
	// Walker state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (save_trigger_in || load_trigger_in) begin
						state <= ST_CMD_RD;
					end
				end
				// Running off the list end counts as end of list
				ST_CMD_RD: state <= ptr[LIST_AW] ? ST_IDLE : ST_CMD;
				ST_CMD: begin
					if (!list_rdata[CMD_OP_BIT]) begin
						state <= ST_AHI_RD;
					end else if (list_rdata[6:0] == OP_COMMIT) begin
						state <= ST_COMMIT;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_AHI_RD: state <= ptr[LIST_AW] ? ST_IDLE : ST_AHI;
				ST_AHI:    state <= ST_ALO_RD;
				ST_ALO_RD: state <= ptr[LIST_AW] ? ST_IDLE : ST_ALO;
				ST_ALO:    state <= save_mode ? ST_BANK_RD : ST_NV_RD;
				ST_BANK_RD:   state <= ST_BANK_WAIT;
				ST_BANK_WAIT: state <= ST_NV_WR;
				ST_NV_WR: begin
					if (nv_ready_in) begin
						state <= last_byte ? ST_CMD_RD : ST_BANK_RD;
					end
				end
				ST_NV_RD: begin
					if (nv_ready_in) begin
						state <= ST_BANK_WR;
					end
				end
				ST_BANK_WR: state <= last_byte ? ST_CMD_RD : ST_NV_RD;
				ST_COMMIT:  state <= ST_CMD_RD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode of the running transfer
	// ----------------------------------------------------------------
	// Save wins if both triggers arrive together
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			save_mode <= 1'b0;
		end else if (state == ST_IDLE && (save_trigger_in || load_trigger_in)) begin
			save_mode <= save_trigger_in;
		end
	end

	// ----------------------------------------------------------------
	// List pointer
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ptr <= '0;
		end else if (state == ST_IDLE) begin
			ptr <= '0;
		end else if (state == ST_CMD || state == ST_AHI || state == ST_ALO) begin
			ptr <= ptr + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Move count and register address
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			remain   <= 7'h00;
			reg_addr <= 16'h0000;
		end else if (state == ST_CMD) begin
			remain <= list_rdata[6:0];
		end else if (state == ST_AHI) begin
			reg_addr[15:8] <= list_rdata;
		end else if (state == ST_ALO) begin
			reg_addr[7:0] <= list_rdata;
		end else if (byte_done && !last_byte) begin
			remain   <= remain - 7'h01;
			reg_addr <= reg_addr + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Store address, runs on through all moves of one transfer
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			nv_addr <= '0;
		end else if (state == ST_IDLE) begin
			nv_addr <= '0;
		end else if (byte_done) begin
			nv_addr <= nv_addr + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Byte in flight
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			data <= 8'h00;
		end else if (state == ST_BANK_WAIT) begin
			data <= bank_rdata_in;
		end else if (state == ST_NV_RD && nv_ready_in) begin
			data <= nv_rdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// One-cycle commit pulse; the bank copies on the next edge
	assign commit_out       = (state == ST_COMMIT);
	assign pending_out      = busy;
	assign save_trigger_out = busy && save_mode;
	assign bank_addr_out    = reg_addr;
	assign bank_rd_out      = (state == ST_BANK_RD);
	assign bank_wr_out      = (state == ST_BANK_WR);
	assign bank_wdata_out   = data;
	assign nv_addr_out      = nv_addr;
	assign nv_rd_out        = (state == ST_NV_RD);
	assign nv_wr_out        = (state == ST_NV_WR);
	assign nv_wdata_out     = data;

endmodule // esw_walker

`default_nettype wire

// ==== shared/esw_pkg.sv ====
// Shared constants and types for the nonvolatile transfer list walker.
// Assumes a 12-bit serial control port address space and byte-wide data.
`default_nettype none

package esw_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [11:0] LIST_BASE     = 12'ha00; // First list byte
	localparam logic [3:0]  LIST_PAGE     = 4'ha;    // Address bits 11:8 of the list area
	localparam int          LIST_DEPTH    = 256;     // List bytes, 0xa00 to 0xaff
	localparam int          LIST_AW       = 8;       // List index width

	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam int          CMD_OP_BIT    = 7;       // Set: operational code
	localparam logic [6:0]  OP_COMMIT     = 7'h00;   // Buffered to active copy
	localparam logic [6:0]  OP_END        = 7'h7f;   // End of list
	localparam logic [7:0]  CMD_COMMIT    = {1'b1, OP_COMMIT};
	localparam logic [7:0]  CMD_END       = {1'b1, OP_END};
	localparam logic [7:0]  CMD_MOVE_MAX  = 8'h7f;   // Move of 128 bytes

	// ----------------------------------------------------------------
	// Default list: two 128-byte moves, a commit, then end codes
	// ----------------------------------------------------------------
	localparam int          DEF_LEN       = 8;       // Bytes through the first end code

	// Reset value of one list byte
	function automatic logic [7:0] esw_default_byte(input int idx);
		logic [7:0] v;
		v = CMD_END;
		case (idx)
			0: v = CMD_MOVE_MAX;
			1: v = 8'h00;
			2: v = 8'h00;
			3: v = CMD_MOVE_MAX;
			4: v = 8'h00;
			5: v = 8'h80;
			6: v = CMD_COMMIT;
			default: v = CMD_END;
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// One access to the list memory
	typedef struct packed {
		logic [LIST_AW-1:0] addr;
		logic [7:0]         wdata;
		logic               wr;
		logic               rd;
	} esw_list_req_t;

	// Walker states
	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD_RD, ST_CMD, ST_AHI_RD, ST_AHI, ST_ALO_RD, ST_ALO,
		ST_BANK_RD, ST_BANK_WAIT, ST_NV_WR, ST_NV_RD, ST_BANK_WR, ST_COMMIT
	} esw_state_t;

endpackage

`default_nettype wire

// ==== hdl/esw_list_mem.sv ====
// Byte memory holding the transfer list, with registered read data.
// Assumes one request per cycle; reset reloads the default list.
`default_nettype none
`timescale 1ns/1ps

module esw_list_mem
	import esw_pkg::*;
#(
	parameter int DEPTH = LIST_DEPTH
) (
	input  wire logic          clock_in,   // System clock
	input  wire logic          sys_rst_in, // Synchronous reset
	input  wire esw_list_req_t req_in,     // Read or write request
	output logic [7:0]         rdata_out   // Data of last read
);

	logic [7:0] mem [DEPTH];                // Flop array so reset can load it

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Reset restores the default list so software need not program it
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= esw_default_byte(i);
			end
		end else if (req_in.wr) begin
			mem[req_in.addr] <= req_in.wdata;
		end
	end

	// Read port, one cycle latency
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			rdata_out <= mem[req_in.addr];
		end
	end

endmodule // esw_list_mem

`default_nettype wire

// ==== tb/esw_walker_props.sv ====
// Port checker for the list walker.
// Assumes a bind from the bench top; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module esw_walker_props #(
	parameter int NV_AW = 9 // Store address width
) (
	input wire logic             clock_in,
	input wire logic             sys_rst_in,
	input wire logic             save_trigger_in,
	input wire logic             save_trigger_out,
	input wire logic             pending_out,
	input wire logic             commit_out,
	input wire logic             bank_rd_out,
	input wire logic             bank_wr_out,
	input wire logic             nv_rd_out,
	input wire logic             nv_wr_out,
	input wire logic             nv_ready_in,
	input wire logic [7:0]       nv_wdata_out,
	input wire logic [NV_AW-1:0] nv_addr_out
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	property p_start; !pending_out && save_trigger_in |=> pending_out && save_trigger_out; endproperty
	a_start: assert property (p_start) else $error("save did not start");
	property p_clr; $fell(save_trigger_out) |-> $fell(pending_out); endproperty
	a_clr: assert property (p_clr) else $error("save bit cleared early");
	property p_idle; !pending_out |-> !(nv_wr_out || nv_rd_out || bank_wr_out || bank_rd_out); endproperty
	a_idle: assert property (p_idle) else $error("traffic while idle");
	property p_cpulse; commit_out |=> !commit_out; endproperty
	a_cpulse: assert property (p_cpulse) else $error("commit too long");
	property p_cbusy; commit_out |-> pending_out; endproperty
	a_cbusy: assert property (p_cbusy) else $error("commit outside walk");
	property p_sdir; save_trigger_out |-> !nv_rd_out && !bank_wr_out; endproperty
	a_sdir: assert property (p_sdir) else $error("save moved wrong way");
	property p_ldir; pending_out && !save_trigger_out |-> !nv_wr_out && !bank_rd_out; endproperty
	a_ldir: assert property (p_ldir) else $error("load moved wrong way");
	property p_hold;
		nv_wr_out && !nv_ready_in |=> nv_wr_out && $stable(nv_wdata_out) && $stable(nv_addr_out);
	endproperty
	a_hold: assert property (p_hold) else $error("store write dropped");
	property p_seq; bank_rd_out |=> !bank_rd_out ##1 nv_wr_out; endproperty
	a_seq: assert property (p_seq) else $error("read not stored");
endmodule // esw_walker_props
`default_nettype wire

// ==== tb/esw_nv_model.sv ====
// Behavioural nonvolatile store with a variable answer delay.
// Assumes requests held until ready; data valid only with ready.
`timescale 1ns/1ps
`default_nettype none
module esw_nv_model (
	input wire logic       clock_in,   // System clock
	input wire logic       sys_rst_in, // Sync reset
	input wire logic [8:0] addr_in,    // Byte address
	input wire logic       rd_in,      // Read request
	input wire logic       wr_in,      // Write request
	input wire logic [7:0] wdata_in,   // Write data
	input wire logic [1:0] dly_in,     // Wait cycles per access
	output logic [7:0]     rdata_out,  // Read data
	output logic           ready_out   // One-cycle done
);
	logic [7:0] mem [512]; // Store cells
	logic [1:0] cnt;       // Wait counter
	// ----
	// Access engine; data toggles when not valid so stale reads show
	// ----
	always_ff @(posedge clock_in) begin
		ready_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (sys_rst_in) begin
			cnt <= 2'h0;
		end else if ((rd_in || wr_in) && !ready_out) begin
			if (cnt >= dly_in) begin
				ready_out <= 1'b1;
				cnt       <= 2'h0;
				rdata_out <= mem[addr_in];
				if (wr_in) begin
					mem[addr_in] <= wdata_in;
				end
			end else begin
				cnt <= cnt + 2'h1;
			end
		end
	end
endmodule // esw_nv_model
`default_nettype wire

// ==== tb/tb_esw_walker.sv ====
// Self-checking bench for the list walker: list port, save, load.
// Assumes the store model beside it; bank modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_esw_walker import esw_pkg::*;;
	logic        clock_in, sys_rst_in, scp_wr, scp_rd, save_trig, load_trig;
	logic [11:0] scp_addr;
	logic [7:0]  scp_wdata, scp_rdata, bank_wdata, nv_wdata, nv_rdata;
	logic [7:0]  bank_rdata = 8'h00;
	logic [15:0] bank_addr;
	logic [8:0]  nv_addr;
	logic [1:0]  nv_dly = 2'h0;
	logic [31:0] rnd = 32'h1c;         // Xorshift state
	logic        rvalid, save_out, pending, commit, bank_rd, bank_wr, nv_rd, nv_wr, nv_ready;
	logic [7:0]  bank [256];           // Register bank model
	int          fails, n_compared, cyc, n_nvw, n_bw, n_cm, exp_c;
	int          exp_a[$];             // Expected register order
	int          dl[$] = '{8'h7f, 0, 0, 8'h7f, 0, 8'h80, CMD_COMMIT, CMD_END};
	int          cl[$] = '{8'h01, 0, 8'h12, CMD_COMMIT, 0, 0, 8'h40, 8'h85};
	esw_walker i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .scp_addr_in(scp_addr),
		.scp_wdata_in(scp_wdata), .scp_wr_in(scp_wr), .scp_rd_in(scp_rd),
		.scp_rdata_out(scp_rdata), .scp_rvalid_out(rvalid), .save_trigger_in(save_trig),
		.load_trigger_in(load_trig), .save_trigger_out(save_out), .pending_out(pending),
		.commit_out(commit), .bank_addr_out(bank_addr), .bank_rd_out(bank_rd),
		.bank_wr_out(bank_wr), .bank_wdata_out(bank_wdata), .bank_rdata_in(bank_rdata),
		.nv_addr_out(nv_addr), .nv_rd_out(nv_rd), .nv_wr_out(nv_wr), .nv_wdata_out(nv_wdata),
		.nv_rdata_in(nv_rdata), .nv_ready_in(nv_ready));
	esw_nv_model i_nv (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(nv_addr),
		.rd_in(nv_rd), .wr_in(nv_wr), .wdata_in(nv_wdata), .dly_in(nv_dly),
		.rdata_out(nv_rdata), .ready_out(nv_ready));
	// One xorshift step; single source of bench randomness
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	// ----
	// Clock, bank answers, counters, watchdog
	// ----
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		bank_rdata <= bank_rd ? bank[bank_addr[7:0]] : ~bank_rdata; // Stale data toggles
		if (bank_wr) bank[bank_addr[7:0]] <= bank_wdata;
		n_nvw += 32'(nv_wr && nv_ready);
		n_bw += 32'(bank_wr);
		n_cm += 32'(commit);
		rnd <= xs(rnd);
		nv_dly <= rnd[1:0];
		cyc++;
		if (cyc == 40000) begin
			fails++;
			results();
		end
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input int i, input int d);
		@(posedge clock_in);
		scp_addr <= {LIST_PAGE, 8'(i)};
		scp_wdata <= 8'(d);
		scp_wr <= 1'b1;
		@(posedge clock_in);
		scp_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input int e);
		@(posedge clock_in);
		scp_addr <= a;
		scp_rd <= 1'b1;
		@(posedge clock_in);
		scp_rd <= 1'b0;
		#1 chk(32'(rvalid), 32'(a[11:8] == LIST_PAGE));
		if (rvalid === 1'b1) chk(32'(scp_rdata), e);
	endtask
	// Reference walk of a list, integers only
	task automatic model(input int l[$]);
		int i, k;
		exp_a = {};
		exp_c = 0;
		i = 0;
		while (i < l.size()) begin
			if (l[i] < 8'h80) begin
				for (k = 0; k <= l[i]; k++) exp_a.push_back(l[i+1] * 256 + l[i+2] + k);
				i += 3;
			end else if (l[i] == CMD_COMMIT) begin
				exp_c++;
				i++;
			end else break;
		end
	endtask
	task automatic run(input bit s);
		int k;
		n_nvw = 0;
		n_bw = 0;
		n_cm = 0;
		@(posedge clock_in);
		save_trig <= s;
		load_trig <= !s;
		@(posedge clock_in);
		save_trig <= 1'b0;
		load_trig <= 1'b0;
		#1 chk(32'(pending), 1);
		chk(32'(save_out), 32'(s));
		k = 0;
		while (k < 5000 && pending === 1'b1) begin
			@(posedge clock_in);
			#1 k++;
		end
		chk(32'(pending), 0);
		chk(32'(save_out), 0);
		chk(n_cm, exp_c);
		chk(s ? n_nvw : n_bw, exp_a.size());
		for (k = 0; k < exp_a.size(); k++) chk(bank[exp_a[k] % 256], i_nv.mem[k]);
	endtask
	task automatic scramble();
		for (int k = 0; k < 256; k++) begin
			@(posedge clock_in);
			bank[k] <= rnd[7:0];
		end
	endtask
	task results();
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		{sys_rst_in, scp_wr, scp_rd, save_trig, load_trig} = 5'h10;
		scp_addr = 12'h000;
		scp_wdata = 8'h00;
		repeat (8) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		for (int k = 0; k < 8; k++) rd(12'ha00 + 12'(k), dl[k]);
		rd(12'haff, CMD_END);
		rd(12'hb00, 0);
		// Bank filled only once reset is over, so reset stays 8 cycles
		scramble();
		model(dl);
		run(1'b1);
		for (int k = 0; k < 8; k++) wr(k, cl[k]);
		rd(12'ha07, 8'h85);
		model(cl);
		run(1'b1);
		scramble();
		run(1'b0);
		// Reset after the load run must bring back the default list
		@(posedge clock_in);
		sys_rst_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		for (int k = 0; k < 8; k++) rd(12'ha00 + 12'(k), dl[k]);
		results();
	end
endmodule // tb_esw_walker
bind esw_walker esw_walker_props #(.NV_AW(NV_AW)) i_props (.clock_in(clock_in),
	.sys_rst_in(sys_rst_in), .save_trigger_in(save_trigger_in),
	.save_trigger_out(save_trigger_out), .pending_out(pending_out), .commit_out(commit_out),
	.bank_rd_out(bank_rd_out), .bank_wr_out(bank_wr_out), .nv_rd_out(nv_rd_out),
	.nv_wr_out(nv_wr_out), .nv_ready_in(nv_ready_in), .nv_wdata_out(nv_wdata_out),
	.nv_addr_out(nv_addr_out));
`default_nettype wire
